/* File: rtl/rsf_pkg.sv */
// constants for the regulator and sensor front-end register bank
package rsf_pkg;
    localparam int unsigned NUM_REGS = 8;
    localparam int unsigned IDX_W = 3;

    // word offsets (byte address = offset)
    localparam logic [7:0] OFS_REGULATOR_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PATH_SWITCH_LOW = 8'h04;
    localparam logic [7:0] OFS_PATH_SWITCH_HIGH = 8'h08;
    localparam logic [7:0] OFS_AMP_SUPPLY_SELECT = 8'h0c;
    localparam logic [7:0] OFS_AMP_CONTROL = 8'h10;
    localparam logic [7:0] OFS_AMP_OFFSET_TRIM = 8'h14;
    localparam logic [7:0] OFS_GAIN_RESISTOR_LOW = 8'h18;
    localparam logic [7:0] OFS_GAIN_RESISTOR_HIGH = 8'h1c;

    // register indices
    localparam logic [2:0] IDX_REGULATOR_CONTROL = 3'h0;
    localparam logic [2:0] IDX_SWLO = 3'h1;
    localparam logic [2:0] IDX_SWHI = 3'h2;
    localparam logic [2:0] IDX_SUPPLY = 3'h3;
    localparam logic [2:0] IDX_AMPC = 3'h4;
    localparam logic [2:0] IDX_TRIM = 3'h5;
    localparam logic [2:0] IDX_RESLO = 3'h6;
    localparam logic [2:0] IDX_RESHI = 3'h7;

    // writable bits of each register, by index
    localparam logic [7:0] WMASK [NUM_REGS] = '{
        8'h87, 8'hff, 8'h01, 8'h03, 8'h43, 8'hff, 8'hff, 8'h01};

    localparam logic [7:0] RESET_VALUE = 8'h00;

    // field positions
    localparam int unsigned POS_REF_SWITCH = 7;
    localparam int unsigned POS_AMP_EN = 6;
    localparam int unsigned POS_AMP_LEVEL = 5;
    localparam int unsigned POS_TRIM_MODE = 7;
    localparam int unsigned POS_TRIM_RESP = 6;

    localparam int unsigned SYNC_STAGES = 3;

    typedef enum logic [2:0] {
        RSF_LDO_HIZ = 3'b000,
        RSF_LDO_BYPASS = 3'b001,
        RSF_LDO_2V2 = 3'b010,
        RSF_LDO_2V5 = 3'b011,
        RSF_LDO_3V0 = 3'b100
    } rsf_ldo_t;
endpackage

/* File: rtl/rsf_regs.sv */
// register bank for the regulator and sensor front end, avalon-mm slave
`timescale 1ns/1ns

// Functional notes
// - Mode low bits 00 give regulator off with a floating output, 01 give off with input passed through.
// - Mode 010 turns the regulator on at 2.2V, 011 at 2.5V and 11x at 3.0V.
// - Regulator control holds the mode in bits 2..0 and the reference switch in bit 7, all reset to 0.
// - Regulator control bits 6..3 are absent and read as zero.
// - The low path-switch register holds eight switch bits, reset 0, where 1 closes a switch.
// - The high path-switch register holds only the ninth switch in bit 0, reset 0, 1 closes it.
// - High path-switch bits 7..1 are absent and read as zero.
// - Amplifier control has enable at bit 6, read-only output status at bit 5 and bandwidth at 1..0.
// - Offset trim holds the calibration mode at 7, the response bit at 6 and a six-bit code at 5..0.
// - The 9-bit resistor setting is split as low eight bits plus a ninth bit at bit 0 of the next.
// - Amplifier supply select has only bits 1 and 0.
// - Each supply bit picks the main supply at 0 and the regulated output at 1, both resetting to 0.
module rsf_regs
    import rsf_pkg::*;
#(
    parameter int unsigned ADDR_W = 6
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic AMP_OUT_I,
    output logic LDO_ON_O,
    output logic LDO_BYPASS_O,
    output logic [2:0] LDO_MODE_O,
    output logic REF_SWITCH_O,
    output logic [8:0] PATH_SWITCH_O,
    output logic [1:0] AMP_SUPPLY_SEL_O,
    output logic AMP_EN_O,
    output logic [1:0] AMP_BW_O,
    output logic TRIM_MODE_O,
    output logic TRIM_RESP_O,
    output logic [5:0] TRIM_CODE_O,
    output logic [8:0] RES_SETTING_O
);

    logic [7:0] mem_reg [NUM_REGS];
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [SYNC_STAGES-1:0] amp_sync_reg;
    logic amp_level_reg;
    rsf_ldo_t ldo_mode_reg;
    rsf_ldo_t ldo_mode_next;
    logic ldo_on_reg;
    logic ldo_byp_reg;
    logic req;
    logic wr_go;
    logic [IDX_W-1:0] idx;
    logic mapped;

    // regulator mode field to regulator state
    function automatic rsf_ldo_t ldo_decode(input logic [2:0] m);
        rsf_ldo_t r;
        r = RSF_LDO_HIZ;
        case (m[1:0])
            2'b00: r = RSF_LDO_HIZ;
            2'b01: r = RSF_LDO_BYPASS;
            2'b10: r = m[2] ? RSF_LDO_3V0 : RSF_LDO_2V2;
            2'b11: r = m[2] ? RSF_LDO_3V0 : RSF_LDO_2V5;
            default: r = RSF_LDO_HIZ;
        endcase
        return r;
    endfunction

    // read view of one register, absent bits forced to zero
    function automatic logic [7:0] reg_view(input logic [IDX_W-1:0] i,
                                            input logic [7:0] v,
                                            input logic lvl);
        logic [7:0] r;
        r = v & WMASK[i];
        if (i == IDX_AMPC) begin
            r[POS_AMP_LEVEL] = lvl;
        end
        return r;
    endfunction

    // bus handshake: one wait state on every access
    assign req = AVS_READ_I | AVS_WRITE_I;
    assign AVS_WAITREQUEST_O = req & ~ack_reg;
    assign idx = AVS_ADDRESS_I[IDX_W+1:2];
    assign mapped = (AVS_ADDRESS_I[ADDR_W-1:IDX_W+2] == '0) && (AVS_ADDRESS_I[1:0] == 2'b00);
    assign wr_go = AVS_WRITE_I & ack_reg & mapped & AVS_BYTEENABLE_I[0];

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // read data captured in the wait cycle, held through the accept edge
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rdata_reg <= 32'h0000_0000;
        end else if (AVS_READ_I && !ack_reg) begin
            rdata_reg <= mapped ? {24'h00_0000, reg_view(idx, mem_reg[idx], amp_level_reg)} : 32'h0000_0000;
        end
    end
    assign AVS_READDATA_O = rdata_reg;

    // register storage; only writable bits ever load
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem_reg[i] <= RESET_VALUE;
            end
        end else if (wr_go) begin
            mem_reg[idx] <= (mem_reg[idx] & ~WMASK[idx]) | (AVS_WRITEDATA_I[7:0] & WMASK[idx]);
        end
    end

    // amplifier output comes from the analogue side, so it is synchronised
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            amp_sync_reg <= '0;
        end else begin
            amp_sync_reg <= {amp_sync_reg[SYNC_STAGES-2:0], AMP_OUT_I};
        end
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            amp_level_reg <= 1'b0;
        end else if (amp_sync_reg[2] == amp_sync_reg[1]) begin
            amp_level_reg <= amp_sync_reg[2];
        end
    end

    assign ldo_mode_next = ldo_decode(mem_reg[IDX_REGULATOR_CONTROL][2:0]);

    // decoded regulator state, registered for glitch-free analogue controls
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ldo_mode_reg <= RSF_LDO_HIZ;
        end else begin
            ldo_mode_reg <= ldo_mode_next;
        end
    end

    // on and bypass flags are flops too, loaded with the state so all three move together
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ldo_on_reg <= 1'b0;
            ldo_byp_reg <= 1'b0;
        end else begin
            ldo_on_reg <= (ldo_mode_next inside {RSF_LDO_2V2, RSF_LDO_2V5, RSF_LDO_3V0});
            ldo_byp_reg <= (ldo_mode_next == RSF_LDO_BYPASS);
        end
    end

    assign LDO_MODE_O = ldo_mode_reg;
    assign LDO_ON_O = ldo_on_reg;
    assign LDO_BYPASS_O = ldo_byp_reg;
    // software keeps this off unless the converter reference is the regulator
    assign REF_SWITCH_O = mem_reg[IDX_REGULATOR_CONTROL][POS_REF_SWITCH];
    assign PATH_SWITCH_O = {mem_reg[IDX_SWHI][0], mem_reg[IDX_SWLO]};
    assign AMP_SUPPLY_SEL_O = mem_reg[IDX_SUPPLY][1:0];
    assign AMP_EN_O = mem_reg[IDX_AMPC][POS_AMP_EN];
    assign AMP_BW_O = mem_reg[IDX_AMPC][1:0];
    assign TRIM_MODE_O = mem_reg[IDX_TRIM][POS_TRIM_MODE];
    assign TRIM_RESP_O = mem_reg[IDX_TRIM][POS_TRIM_RESP];
    assign TRIM_CODE_O = mem_reg[IDX_TRIM][5:0];
    assign RES_SETTING_O = {mem_reg[IDX_RESHI][0], mem_reg[IDX_RESLO]};

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    logic [7:0] wd8;
    assign wd8 = AVS_WRITEDATA_I[7:0];

    hiz_mode_a: assert property (
        wr_go && idx == IDX_REGULATOR_CONTROL && wd8[1:0] == 2'b00 |-> ##2 LDO_MODE_O == RSF_LDO_HIZ && !LDO_ON_O
    ) else $error("mode x00 did not float the regulator");

    bypass_mode_a: assert property (
        wr_go && idx == IDX_REGULATOR_CONTROL && wd8[1:0] == 2'b01 |-> ##2 LDO_BYPASS_O && !LDO_ON_O
    ) else $error("mode x01 did not select bypass");

    level_sel_a: assert property (
        wr_go && idx == IDX_REGULATOR_CONTROL && wd8[1] |->
        ##2 LDO_ON_O &&
        LDO_MODE_O == ($past(wd8[2], 2) ? RSF_LDO_3V0 : ($past(wd8[0], 2) ? RSF_LDO_2V5 : RSF_LDO_2V2))
    ) else $error("regulator level does not follow mode");

    ref_switch_a: assert property (
        wr_go && idx == IDX_REGULATOR_CONTROL |=> REF_SWITCH_O == $past(wd8[POS_REF_SWITCH])
    ) else $error("reference switch not loaded");

    regulator_control_zero_a: assert property (
        AVS_READ_I && !ack_reg && mapped && idx == IDX_REGULATOR_CONTROL |=> AVS_READDATA_O[6:3] == 4'h0
    ) else $error("regulator control bits 6..3 not zero");

    path_switch_a: assert property (
        wr_go && idx == IDX_SWLO |=> PATH_SWITCH_O[7:0] == $past(wd8) ##1 $stable(PATH_SWITCH_O) || $past(wr_go)
    ) else $error("low path switches not loaded");

    ninth_sw_a: assert property (
        wr_go && idx == IDX_SWHI |=> PATH_SWITCH_O[8] == $past(wd8[0])
    ) else $error("ninth switch not loaded");

    swhi_zero_a: assert property (
        AVS_READ_I && !ack_reg && mapped && idx == IDX_SWHI |=> AVS_READDATA_O[7:1] == 7'h00
    ) else $error("high path switch bits 7..1 not zero");

    amp_status_a: assert property (
        amp_sync_reg[2] == amp_sync_reg[1] |=> amp_level_reg == $past(amp_sync_reg[2])
    ) else $error("amplifier status not following filtered input");

    amp_ctrl_a: assert property (
        wr_go && idx == IDX_AMPC |=> AMP_EN_O == $past(wd8[POS_AMP_EN]) && AMP_BW_O == $past(wd8[1:0])
    ) else $error("amplifier control not loaded");

    trim_a: assert property (
        wr_go && idx == IDX_TRIM |=> {TRIM_MODE_O, TRIM_RESP_O, TRIM_CODE_O} == $past(wd8)
    ) else $error("trim register not loaded");

    res_split_a: assert property (
        wr_go && idx == IDX_RESHI |=> RES_SETTING_O[8] == $past(wd8[0]) && $stable(RES_SETTING_O[7:0])
    ) else $error("resistor ninth bit not loaded");

    supply_a: assert property (
        AVS_READ_I && !ack_reg && mapped && idx == IDX_SUPPLY |=>
        AVS_READDATA_O[7:0] == {6'h00, AMP_SUPPLY_SEL_O}
    ) else $error("supply select reads wrong");

    supply_wr_a: assert property (
        wr_go && idx == IDX_SUPPLY |=> AMP_SUPPLY_SEL_O == $past(wd8[1:0])
    ) else $error("supply select not loaded");

    no_write_a: assert property (
        !RST_I && !wr_go |=> $stable(PATH_SWITCH_O) && $stable(RES_SETTING_O) && $stable(AMP_SUPPLY_SEL_O)
    ) else $error("register changed without a write");

    wait_once_a: assert property (
        req && !ack_reg |=> !AVS_WAITREQUEST_O || !req
    ) else $error("more than one wait state");

    reset_clear_a: assert property (
        @(posedge CLK_I) disable iff (1'b0) RST_I |=> PATH_SWITCH_O == 9'h000 && !REF_SWITCH_O
    ) else $error("reset did not clear registers");

    reset_rest_a: assert property (
        @(posedge CLK_I) disable iff (1'b0) RST_I |=>
        LDO_MODE_O == RSF_LDO_HIZ && !LDO_ON_O && !LDO_BYPASS_O && AMP_SUPPLY_SEL_O == 2'b00 &&
        !AMP_EN_O && AMP_BW_O == 2'b00 && !TRIM_MODE_O && !TRIM_RESP_O && TRIM_CODE_O == 6'h00 &&
        RES_SETTING_O == 9'h000
    ) else $error("reset left a control set");

    ldo_flags_a: assert property (
        LDO_ON_O == (LDO_MODE_O inside {RSF_LDO_2V2, RSF_LDO_2V5, RSF_LDO_3V0}) &&
        LDO_BYPASS_O == (LDO_MODE_O == RSF_LDO_BYPASS)
    ) else $error("regulator flags disagree with decoded state");

    mode_hold_a: assert property (
        !RST_I && !wr_go |-> ##2 $stable(LDO_MODE_O) && $stable(LDO_ON_O) && $stable(LDO_BYPASS_O)
    ) else $error("regulator state moved without a write");

    res_low_a: assert property (
        wr_go && idx == IDX_RESLO |=> RES_SETTING_O[7:0] == $past(wd8) && $stable(RES_SETTING_O[8])
    ) else $error("resistor low byte not loaded");

    amp_rd_level_a: assert property (
        AVS_READ_I && !ack_reg && mapped && idx == IDX_AMPC |=>
        AVS_READDATA_O[POS_AMP_LEVEL] == $past(amp_level_reg)
    ) else $error("status bit read does not follow amplifier");

    ampc_zero_a: assert property (
        AVS_READ_I && !ack_reg && mapped && idx == IDX_AMPC |=>
        AVS_READDATA_O[7] == 1'b0 && AVS_READDATA_O[4:2] == 3'h0
    ) else $error("amplifier control absent bits not zero");

    reshi_zero_a: assert property (
        AVS_READ_I && !ack_reg && mapped && idx == IDX_RESHI |=> AVS_READDATA_O[7:1] == 7'h00
    ) else $error("resistor high bits 7..1 not zero");

    regulator_control_rd_a: assert property (
        AVS_READ_I && !ack_reg && mapped && idx == IDX_REGULATOR_CONTROL |=>
        AVS_READDATA_O[7] == $past(REF_SWITCH_O) && AVS_READDATA_O[2:0] == $past(mem_reg[IDX_REGULATOR_CONTROL][2:0])
    ) else $error("regulator control reads wrong");

    swlo_rd_a: assert property (
        AVS_READ_I && !ack_reg && mapped && idx == IDX_SWLO |=>
        AVS_READDATA_O[7:0] == $past(PATH_SWITCH_O[7:0])
    ) else $error("low path switches read wrong");

    rd_upper_a: assert property (
        AVS_READ_I && !ack_reg |=> AVS_READDATA_O[31:8] == 24'h00_0000
    ) else $error("read data upper bytes not zero");

    unmapped_rd_a: assert property (
        AVS_READ_I && !ack_reg && !mapped |=> AVS_READDATA_O == 32'h0000_0000
    ) else $error("unmapped read not zero");

    ignored_wr_a: assert property (
        !RST_I && AVS_WRITE_I && ack_reg && !(mapped && AVS_BYTEENABLE_I[0]) |=>
        $stable(PATH_SWITCH_O) && $stable(RES_SETTING_O) && $stable(REF_SWITCH_O) && $stable(AMP_EN_O)
    ) else $error("ignored write changed a register");

    ctrl_hold_a: assert property (
        !RST_I && !wr_go |=> $stable(REF_SWITCH_O) && $stable(AMP_EN_O) && $stable(AMP_BW_O) &&
        $stable(TRIM_MODE_O) && $stable(TRIM_RESP_O) && $stable(TRIM_CODE_O)
    ) else $error("control bit changed without a write");

    level_hold_a: assert property (
        amp_sync_reg[2] != amp_sync_reg[1] |=> $stable(amp_level_reg)
    ) else $error("status moved while sync stages disagree");

    wait_first_a: assert property (
        req && !ack_reg |-> AVS_WAITREQUEST_O
    ) else $error("request accepted without a wait state");

    ack_pulse_a: assert property (
        ack_reg |=> !ack_reg
    ) else $error("accept lasted more than one cycle");

    ack_idle_a: assert property (
        !req |=> !ack_reg
    ) else $error("accept without a request");

    rdata_hold_a: assert property (
        ack_reg |=> $stable(AVS_READDATA_O)
    ) else $error("read data moved after accept");

    for (genvar g = 0; g < NUM_REGS; g++) begin : g_mask
        mask_hold_a: assert property (
            @(posedge CLK_I) disable iff (RST_I) (mem_reg[g] & ~WMASK[g]) == 8'h00
        ) else $error("absent register bit holds a one");
    end

    wr_regulator_control_c: cover property (wr_go && idx == IDX_REGULATOR_CONTROL && wd8[2:1] == 2'b11);
    rd_ampc_c: cover property (AVS_READ_I && ack_reg && idx == IDX_AMPC && AVS_READDATA_O[POS_AMP_LEVEL]);
    b2b_c: cover property (wr_go ##1 req ##1 req && ack_reg);
    unmapped_c: cover property (AVS_READ_I && ack_reg && !mapped);
    mid_reset_c: cover property (@(posedge CLK_I) disable iff (1'b0) !RST_I ##1 RST_I ##1 !RST_I);

endmodule

/* File: test/tb.sv */
// self-checking bench for the regulator and front-end register bank
`timescale 1ns/1ns
module tb;
    import rsf_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, amp_out = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata, rnd = 32'hf0fd;
    logic [3:0] be = 4'hf;
    logic waitreq, ldo_on, ldo_byp, ref_sw, amp_en, t_mode, t_resp;
    logic [2:0] ldo_mode;
    logic [8:0] path_sw, res_set;
    logic [1:0] sup_sel, amp_bw;
    logic [5:0] t_code;
    logic [7:0] sh [NUM_REGS];
    logic [7:0] d;
    int failures = 0, n_tests = 0;
    rsf_regs DUT (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
        .AMP_OUT_I(amp_out), .LDO_ON_O(ldo_on), .LDO_BYPASS_O(ldo_byp), .LDO_MODE_O(ldo_mode),
        .REF_SWITCH_O(ref_sw), .PATH_SWITCH_O(path_sw), .AMP_SUPPLY_SEL_O(sup_sel), .AMP_EN_O(amp_en),
        .AMP_BW_O(amp_bw), .TRIM_MODE_O(t_mode), .TRIM_RESP_O(t_resp), .TRIM_CODE_O(t_code),
        .RES_SETTING_O(res_set));
    initial begin
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // decoded regulator state expected for a mode code
    function automatic logic [2:0] exp_mode(input logic [2:0] c);
        if (c[1:0] == 2'b00) return 3'h0;
        if (c[1:0] == 2'b01) return 3'h1;
        return c[2] ? 3'h4 : c;
    endfunction
    task automatic close_out();
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // master holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v, input logic [3:0] b,
                       output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, v};
        be <= b;
        rd <= ~w;
        wr <= w;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] v, input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, a, v, b, q);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 4'hf, q);
        chk(q, {24'h0, e});
    endtask
    task automatic chk_all();
        for (int i = 0; i < NUM_REGS; i++) rd_chk(6'(i * 4), sh[i]);
        chk(32'(path_sw), {23'h0, sh[2][0], sh[1]});
        chk(32'(res_set), {23'h0, sh[7][0], sh[6]});
        chk(32'(sup_sel), 32'(sh[3][1:0]));
        chk({29'h0, ref_sw, amp_en, t_mode}, {29'h0, sh[0][7], sh[4][6], sh[5][7]});
        chk({23'h0, amp_bw, t_resp, t_code}, {23'h0, sh[4][1:0], sh[5][6:0]});
    endtask
    initial begin
        #200000;
        failures++;
        close_out();
    end
    initial begin
        for (int i = 0; i < NUM_REGS; i++) sh[i] = RESET_VALUE;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        chk_all();
        for (int k = 0; k < 24; k++) begin
            rnd = xs(rnd);
            d = (k < 8) ? 8'hff : rnd[15:8];
            wr_reg(6'(rnd[2:0] * 4), d, 4'hf);
            sh[rnd[2:0]] = d & WMASK[rnd[2:0]];
            if (k % 6 == 5) chk_all();
        end
        wr_reg(6'h04, ~sh[1], 4'he); // ignored without the low byte enable
        wr_reg(6'h20, 8'hff, 4'hf);
        wr_reg(6'h06, 8'hff, 4'hf);
        rd_chk(6'h24, 8'h00);
        rd_chk(6'h01, 8'h00);
        chk_all();
        for (int c = 0; c < 8; c++) begin
            rnd = xs(rnd);
            sh[0] = {rnd[7], 4'h0, 3'(c)}; // reference taken as the regulator, so the switch may close
            wr_reg(6'h00, {rnd[7], rnd[6:3], 3'(c)}, 4'hf);
            repeat (3) @(posedge clk);
            chk(32'(ldo_mode), 32'(exp_mode(3'(c))));
            chk({30'h0, ldo_on, ldo_byp}, {30'h0, exp_mode(3'(c)) > 3'h1, exp_mode(3'(c)) == 3'h1});
            rd_chk(6'h00, sh[0]);
        end
        wr_reg(6'h10, 8'hff, 4'hf); // status bit is not writable
        sh[4] = 8'h43;
        rd_chk(6'h10, 8'h43);
        amp_out <= 1'b1;
        repeat (8) @(posedge clk);
        rd_chk(6'h10, 8'h63);
        amp_out <= 1'b0;
        repeat (8) @(posedge clk);
        rd_chk(6'h10, 8'h43);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < NUM_REGS; i++) sh[i] = RESET_VALUE;
        chk_all();
        chk(32'(ldo_mode), 32'h0);
        close_out();
    end
endmodule
